// ==== sac_ctrl.sv ====
/*
  Sample/convert/read control of a 12-bit successive-approximation converter.
  Host pins arrive asynchronously and pass three flip-flops; chip select gates
  both trigger edges. Finished results and abort markers pass through an
  8-word FIFO; the read latch takes the oldest pending code whenever the bus
  is idle, so an open read never changes under the host.
  Assumes the analog core holds its code on conv_code through the last step
  of the internal step counter and that mclk is the only clock.
*/
`timescale 1ns/1ns
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int CONV_CYC = sac_pkg::CONV_CYCLES,
  parameter int DEPTH = sac_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // host control pins
  input wire logic conv_trigger_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic fold_sel,
  // analog core
  input wire logic [sac_pkg::RESULT_W-1:0] conv_code,
  output logic sample_on,
  output logic conv_start,
  // status and data bus
  output logic busy,
  output logic [sac_pkg::RESULT_W-1:0] data_out,
  output logic [sac_pkg::RESULT_W-1:0] data_oe,
  output logic result_lost
);
  import sac_pkg::*;

  // gray along idle, sample, convert
  typedef enum logic [1:0] {
    SAC_IDLE   = 2'b00,
    SAC_SAMPLE = 2'b01,
    SAC_CONV   = 2'b11
  } sac_state_t;

  // ===========================================
  // input synchronisers
  logic [SYNC_STAGES-1:0] trig_sh;
  logic [SYNC_STAGES-1:0] cs_sh;
  logic [SYNC_STAGES-1:0] rd_sh;
  logic [SYNC_STAGES-1:0] fold_sh;
  logic trig_q;
  logic cs_q;
  logic rd_q;
  logic fold_q;

  // reset to the idle pin levels so no false edge follows reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_sh <= '1;
      cs_sh <= '1;
      rd_sh <= '1;
      fold_sh <= '0;
    end else begin
      trig_sh <= {trig_sh[SYNC_STAGES-2:0], conv_trigger_n};
      cs_sh <= {cs_sh[SYNC_STAGES-2:0], cs_n};
      rd_sh <= {rd_sh[SYNC_STAGES-2:0], rd_n};
      fold_sh <= {fold_sh[SYNC_STAGES-2:0], fold_sel};
    end
  end

  // a change counts once the second and third stages agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_q <= 1'b1;
      cs_q <= 1'b1;
      rd_q <= 1'b1;
      fold_q <= 1'b0;
    end else begin
      if (trig_sh[1] == trig_sh[2]) begin
        trig_q <= trig_sh[2];
      end
      if (cs_sh[1] == cs_sh[2]) begin
        cs_q <= cs_sh[2];
      end
      if (rd_sh[1] == rd_sh[2]) begin
        rd_q <= rd_sh[2];
      end
      if (fold_sh[1] == fold_sh[2]) begin
        fold_q <= fold_sh[2];
      end
    end
  end

  // ===========================================
  // edge detection on the filtered levels
  logic trig_d;
  logic cs_d;
  logic trig_rise;
  logic trig_fall;
  logic cs_fall;

  always_ff @(posedge mclk) begin
    if (rst) begin
      trig_d <= 1'b1;
      cs_d <= 1'b1;
    end else begin
      trig_d <= trig_q;
      cs_d <= cs_q;
    end
  end

  function automatic logic rose(input logic cur, input logic prev);
    rose = cur && !prev;
  endfunction

  function automatic logic fell(input logic cur, input logic prev);
    fell = !cur && prev;
  endfunction

  assign trig_rise = rose(trig_q, trig_d);
  assign trig_fall = fell(trig_q, trig_d);
  assign cs_fall = fell(cs_q, cs_d);

  // ===========================================
  // sample / convert sequencer
  localparam int CW = $clog2(CONV_CYC + 1);
  sac_state_t state;
  sac_state_t next_state;
  logic [CW-1:0] conv_cnt;
  logic conv_end;
  logic start_conv;
  logic abort_now;

  assign conv_end = (state == SAC_CONV) && (conv_cnt == CW'(CONV_CYC - 1));
  // chip select gates the trigger edge; with the trigger already low the
  // falling chip select itself starts the conversion
  assign start_conv = (state == SAC_SAMPLE) &&
                      ((trig_fall && !cs_q) || (cs_fall && !trig_q));
  assign abort_now = (state == SAC_CONV) && cs_fall && trig_q;

  always_comb begin
    next_state = state;
    case (state)
      SAC_IDLE: begin
        if (trig_rise && !cs_q) begin
          next_state = SAC_SAMPLE;
        end else if (cs_fall && trig_q) begin
          next_state = SAC_SAMPLE;
        end
      end
      SAC_SAMPLE: begin
        if (start_conv) begin
          next_state = SAC_CONV;
        end
      end
      SAC_CONV: begin
        // an abort wins over the normal end in the same cycle
        if (abort_now) begin
          next_state = SAC_IDLE;
        end else if (conv_end) begin
          // back-to-back: resample at the internal end
          next_state = (!cs_q && trig_q) ? SAC_SAMPLE : SAC_IDLE;
        end
      end
      default: begin
        next_state = SAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= SAC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // internal conversion clock: one step per mclk cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      conv_cnt <= '0;
    end else if (state != SAC_CONV || conv_end) begin
      conv_cnt <= '0;
    end else begin
      conv_cnt <= conv_cnt + 1'b1;
    end
  end

  // busy tracks the conversion state
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_state == SAC_CONV);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sample_on <= 1'b0;
    end else begin
      sample_on <= (next_state == SAC_SAMPLE);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= start_conv;
    end
  end

  // ===========================================
  // result path through the FIFO
  logic push;
  logic [RESULT_W-1:0] push_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [RESULT_W-1:0] fifo_out_data;
  logic reading;
  logic pop;
  logic [RESULT_W-1:0] result;

  assign push = conv_end || abort_now;
  assign push_data = abort_now ? ABORT_CODE : conv_code;
  assign reading = !cs_q && !rd_q;
  // the latch only advances while the bus is idle so a read stays stable
  assign pop = fifo_out_valid && !reading;

  sac_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(!reading),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      result <= RESULT_RESET;
    end else if (pop) begin
      result <= fifo_out_data;
    end
  end

  // a finished code that found the FIFO full is dropped and flagged; the flag
  // clears when a read opens, so a read held across the loss still shows it
  logic reading_d;
  logic read_start;

  always_ff @(posedge mclk) begin
    if (rst) begin
      reading_d <= 1'b0;
    end else begin
      reading_d <= reading;
    end
  end

  assign read_start = rose(reading, reading_d);

  always_ff @(posedge mclk) begin
    if (rst) begin
      result_lost <= 1'b0;
    end else if (push && !fifo_in_ready) begin
      result_lost <= 1'b1;
    end else if (read_start) begin
      result_lost <= 1'b0;
    end
  end

  // ===========================================
  // output bus drivers
  function automatic logic [RESULT_W-1:0] fold_view(input logic [RESULT_W-1:0] r,
                                                    input logic f);
    if (f) begin
      fold_view = {r[FOLD_BITS-1:0], {(RESULT_W-FOLD_BITS){1'b0}}};
    end else begin
      fold_view = r;
    end
  endfunction

  always_ff @(posedge mclk) begin
    if (rst) begin
      data_out <= '0;
    end else begin
      data_out <= fold_view(result, fold_q);
    end
  end

  // all twelve enables move together so the bus is never half driven
  always_ff @(posedge mclk) begin
    if (rst) begin
      data_oe <= '0;
    end else begin
      data_oe <= reading ? '1 : '0;
    end
  end
endmodule

// ==== sac_pkg.sv ====
/*
  Constants shared by the converter control block: result format, marker code,
  conversion timing and FIFO sizing.
  Assumes a single 10 MHz clock mclk and a synchronous active-high reset.
*/
// Function
// - a rising trigger while chip select and busy are low starts sampling.
// - chip select falling while the trigger is high and busy is low starts sampling.
// - with chip select low and the trigger already high, sampling restarts at conversion end.
// - a falling trigger ends sampling and starts a conversion; sac_ctrl does so only while chip select is low.
// - chip select falling while the trigger is low ends sampling and starts a conversion.
// - busy rises right after a conversion start, stays high throughout and falls at the end.
// - chip select falling while busy and the trigger are high aborts the conversion.
// - an aborted conversion leaves the marker code FE0 hex as the result.
// - result bits 11 to 0 are driven onto the bus only while chip select and read are low.
// - the data outputs are released whenever chip select or read strobe is high.
// - with fold select low a read shows the full twelve-bit result.
// - with fold select high a read shows bits 3 to 0 on top, then zeros.
// - a read shows the result of the previously completed conversion.
// - the conversion clock is internal and a conversion completes within 200 ns.
package sac_pkg;
  localparam int RESULT_W = 12;
  localparam logic [11:0] ABORT_CODE = 12'hfe0;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam int FOLD_BITS = 4;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_MAX_NS = 200;
  // longest time rounds down, never below one cycle
  localparam int CONV_CYCLES_RAW = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_STAGES = 3;
endpackage

// ==== sac_fifo.sv ====
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module sac_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ==== sac_ctrl_props.sv ====
/*
  Port checker for sac_ctrl.
  Bound from tb; one clock mclk, synchronous reset rst.
*/
`timescale 1ns/1ns
module sac_ctrl_props
  import sac_pkg::*;
#(
  parameter int CONV_CYC = sac_pkg::CONV_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // host pins
  input wire logic conv_trigger_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic fold_sel,
  // core, status and bus
  input wire logic [sac_pkg::RESULT_W-1:0] conv_code,
  input wire logic sample_on,
  input wire logic conv_start,
  input wire logic busy,
  input wire logic [sac_pkg::RESULT_W-1:0] data_out,
  input wire logic [sac_pkg::RESULT_W-1:0] data_oe,
  input wire logic result_lost
);
  logic [7:0] bcnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ====================
  // busy length and properties
  always_ff @(posedge mclk) begin
    if (rst || !busy) begin
      bcnt <= 8'h00;
    end else begin
      bcnt <= bcnt + 8'h01;
    end
  end
  start_busy_a: assert property (conv_start |-> ##[0:1] busy)
    else $error("no busy after start");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  sample_stop_a: assert property (conv_start |=> !sample_on)
    else $error("sampling went on");
  busy_bound_a: assert property (busy |-> int'(bcnt) < CONV_CYC)
    else $error("conversion too long");
  oe_whole_a: assert property (data_oe == '0 || data_oe == '1)
    else $error("partial bus drive");
  oe_release_a: assert property ((cs_n || rd_n) [*6] |-> data_oe == '0)
    else $error("bus not released");
  oe_drive_a: assert property ((!cs_n && !rd_n) [*6] |-> data_oe == '1)
    else $error("bus not driven");
  fold_zero_a: assert property (
    (fold_sel && !cs_n && !rd_n) [*6] |-> data_out[7:0] == 8'h00)
    else $error("folded low bits set");
  conv_c: cover property (conv_start);
  abort_c: cover property ($fell(cs_n) && busy);
  lost_c: cover property (result_lost);
endmodule

// ==== sac_core_model.sv ====
/*
  Behavioural analog core: hands back the code chosen by the bench.
  Assumes conv_start and busy come from sac_ctrl on mclk.
*/
`timescale 1ns/1ns
module sac_core_model
  import sac_pkg::*;
(
  // clock
  input wire logic mclk,
  // control from the block
  input wire logic conv_start,
  input wire logic busy,
  // code in and out
  input wire logic [sac_pkg::RESULT_W-1:0] code,
  output logic [sac_pkg::RESULT_W-1:0] conv_code
);
  logic [1:0] hold = 2'h0;
  // ====================
  // code valid from start until just after busy falls
  always_ff @(posedge mclk) begin
    if (conv_start || busy) begin
      hold <= 2'h2;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end
  end
  // outside a conversion show the inverse, never a stale copy
  assign conv_code = (hold != 2'h0 || conv_start) ? code : ~code;
endmodule

// ==== tb.sv ====
/*
  Self-checking bench for sac_ctrl with core model and checker.
  Assumes sac_pkg, sac_fifo and sac_ctrl are compiled first.
*/
`timescale 1ns/1ns
module tb;
  import sac_pkg::*;
  localparam int CC = 16;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic conv_trigger_n = 1'b1;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic fold_sel = 1'b0;
  logic [RESULT_W-1:0] code = '0;
  logic [RESULT_W-1:0] conv_code, data_out, data_oe;
  logic sample_on, conv_start, busy, result_lost;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  always #50 mclk = ~mclk;
  sac_core_model sac_core_model_inst (.mclk(mclk), .conv_start(conv_start), .busy(busy),
    .code(code), .conv_code(conv_code));
  sac_ctrl #(.CONV_CYC(CC), .DEPTH(FIFO_DEPTH)) sac_ctrl_inst (.mclk(mclk), .rst(rst),
    .conv_trigger_n(conv_trigger_n), .cs_n(cs_n), .rd_n(rd_n), .fold_sel(fold_sel),
    .conv_code(conv_code), .sample_on(sample_on), .conv_start(conv_start), .busy(busy),
    .data_out(data_out), .data_oe(data_oe), .result_lost(result_lost));
  // ====================
  // tasks
  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({11'h000, got}, {11'h000, exp});
  endtask
  function automatic logic [RESULT_W-1:0] folded(input logic [RESULT_W-1:0] c);
    return {c[3:0], 8'h00};
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic wbusy(input logic lvl, output int n);
    n = 0;
    while (busy !== lvl && n < 300) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic conv(input int mode, input logic [RESULT_W-1:0] c);
    int n;
    int m;
    code <= c;
    cs_n <= (mode == 1);
    wt(6);
    @(posedge mclk);
    conv_trigger_n <= 1'b1;
    wt(6);
    chk1(sample_on, mode != 1);
    @(posedge mclk);
    cs_n <= 1'b0;
    wt(6);
    chk1(sample_on, 1'b1);
    @(posedge mclk);
    cs_n <= (mode == 1);
    wt(6);
    @(posedge mclk);
    conv_trigger_n <= 1'b0;
    if (mode == 1) begin
      wt(6);
      chk1(sample_on, 1'b1);
      @(posedge mclk);
      cs_n <= 1'b0;
    end
    wbusy(1'b1, n);
    chk1(n <= 8, 1'b1);
    m = (mode == 2) ? 4 : 0;
    repeat (m) @(posedge mclk);
    if (mode == 2) conv_trigger_n <= 1'b1;
    wbusy(1'b0, n);
    chk1(n + m == CC, 1'b1);
    chk1(sample_on, mode == 2);
  endtask
  task automatic rd(input logic [RESULT_W-1:0] c);
    rd_n <= 1'b0;
    fold_sel <= 1'b0;
    wt(6);
    chk(data_oe, '1);
    chk(data_out, c);
    @(posedge mclk);
    fold_sel <= 1'b1;
    wt(6);
    chk(data_out, folded(c));
    @(posedge mclk);
    cs_n <= 1'b1;
    wt(6);
    chk(data_oe, '0);
    @(posedge mclk);
    rd_n <= 1'b1;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      summarize;
    end
  end
  // ====================
  // main sequence
  initial begin
    logic [RESULT_W-1:0] c;
    int n;
    void'($urandom(32'h73f4_8661));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk1(busy, 1'b0);
    chk(data_oe, '0);
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      c = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'($urandom);
      @(posedge mclk);
      conv(i % 3, c);
      wt(6);
      @(posedge mclk);
      rd(c);
    end
    // chip select falls mid-conversion with the trigger high
    @(posedge mclk);
    cs_n <= 1'b0;
    wt(6);
    @(posedge mclk);
    conv_trigger_n <= 1'b0;
    wbusy(1'b1, n);
    cs_n <= 1'b1;
    conv_trigger_n <= 1'b1;
    repeat (4) @(posedge mclk);
    cs_n <= 1'b0;
    wbusy(1'b0, n);
    chk1(n < CC - 4, 1'b1);
    wt(6);
    @(posedge mclk);
    rd(ABORT_CODE);
    // hold a read open while ten results arrive
    @(posedge mclk);
    rd_n <= 1'b0;
    fold_sel <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      conv(0, 12'($urandom));
    end
    wt(6);
    chk(data_out, ABORT_CODE);
    chk1(result_lost, 1'b1);
    summarize;
  end
endmodule
bind sac_ctrl sac_ctrl_props #(.CONV_CYC(CONV_CYC)) sac_ctrl_props_inst (.mclk(mclk),
  .rst(rst), .conv_trigger_n(conv_trigger_n), .cs_n(cs_n), .rd_n(rd_n),
  .fold_sel(fold_sel), .conv_code(conv_code), .sample_on(sample_on),
  .conv_start(conv_start), .busy(busy), .data_out(data_out), .data_oe(data_oe),
  .result_lost(result_lost));
